// >>> pkg/spm_pkg.sv
// constants and types shared by the serial port master files
// assumes a single 25 MHz clock domain and an AXI4-Lite register bus
package spm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hbb;
  localparam logic [7:0] IDX_STAT = 8'hbc;
  localparam logic [7:0] IDX_DATA = 8'hbd;
  localparam logic [7:0] IDX_CLKC = 8'hbe;
  localparam logic [7:0] IDX_BAUD = 8'hbf;

  ////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int CTRL_MODE = 1;
  localparam int CTRL_SHARED_OE = 2;
  localparam int STAT_IDLE = 0;
  localparam int STAT_DONE = 1;
  localparam int CLKC_TEDGE = 0;
  localparam int CLKC_CPOL = 1;
  localparam int CLKC_SRC = 2;
  localparam int CLKC_GATE = 3;
  localparam int CLKC_REDGE = 4;
  localparam int CLKC_W = 5;
  localparam int BAUD_W = 3;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_SHARED_OE = 1'b0;
  localparam logic [4:0] RST_CLKC = 5'h00;
  localparam logic [2:0] RST_BAUD = 3'h0;
  localparam logic [7:0] RST_DATA = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // counts and bus answers
  localparam logic [3:0] LAST_PHASE = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {SH_IDLE, SH_RUN} spm_state_type;

endpackage

// >>> rtl/spm_shifter.sv
// eight-bit serial shift engine with independent transmit and receive edges
// assumes tick pulses at least two clocks apart, each one a serial clock edge
`timescale 1ns/1ps
module spm_shifter (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic cpol,
  input wire logic tedge,
  input wire logic redge,
  input wire logic sin,
  output logic sclk,
  output logic sdo,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);

  spm_pkg::spm_state_type state_ff;
  logic [3:0] phase_ff;
  logic [7:0] sh_ff;
  logic lead;

  assign lead = ~phase_ff[0];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= spm_pkg::SH_IDLE;
      phase_ff <= 4'h0;
      sh_ff <= 8'h00;
      sclk <= 1'b0;
      sdo <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
    end else if (clear) begin
      state_ff <= spm_pkg::SH_IDLE;
      phase_ff <= 4'h0;
      sclk <= cpol;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        spm_pkg::SH_IDLE: begin
          sclk <= cpol; // idle level follows polarity
          if (start) begin
            state_ff <= spm_pkg::SH_RUN;
            phase_ff <= 4'h0;
            busy <= 1'b1;
            // trailing-edge shifting presents bit 7 before the first edge
            sh_ff <= tedge ? tx_byte : {tx_byte[6:0], 1'b0};
            sdo <= tedge ? sdo : tx_byte[7];
          end
        end
        spm_pkg::SH_RUN: begin
          if (tick) begin
            sclk <= ~sclk;
            phase_ff <= phase_ff + 4'h1;
            if (tedge ? lead : (!lead && phase_ff != spm_pkg::LAST_PHASE)) begin
              sdo <= sh_ff[7];
              sh_ff <= {sh_ff[6:0], 1'b0};
            end
            if (redge ? !lead : lead) begin
              rx_byte <= {rx_byte[6:0], sin};
            end
            if (phase_ff == spm_pkg::LAST_PHASE) begin
              state_ff <= spm_pkg::SH_IDLE;
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end
        default: state_ff <= spm_pkg::SH_IDLE;
      endcase
    end
  end

endmodule // spm_shifter

// >>> rtl/spm_port.sv
// master-only three-pin serial port with pin sharing and an AXI4-Lite slave
// assumes port_power_down_in comes from logic on the same clock
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module spm_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_power_down_in,
  input wire logic ring_oscillator_clock,
  input wire logic pll_clock_input,
  input wire logic shared_gpio_a_level,
  input wire logic shared_gpio_a_dir,
  input wire logic shared_gpio_b_level,
  input wire logic shared_gpio_b_dir,
  input wire logic shared_gpio_c_level,
  input wire logic shared_gpio_c_dir,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic data_out_pin_i,
  output logic data_out_pin_o,
  output logic data_out_pin_oe,
  input wire logic data_in_pin_i,
  output logic data_in_pin_o,
  output logic data_in_pin_oe,
  output logic port_interrupt
);

  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    return addr[11:2] == {2'b00, idx};
  endfunction

  function automatic logic reg_mapped(input logic [11:0] addr);
    return reg_hit(addr, spm_pkg::IDX_CTRL) || reg_hit(addr, spm_pkg::IDX_STAT) ||
      reg_hit(addr, spm_pkg::IDX_DATA) || reg_hit(addr, spm_pkg::IDX_CLKC) ||
      reg_hit(addr, spm_pkg::IDX_BAUD);
  endfunction

  logic fs_ff;
  logic mode_ff;
  logic shared_oe_ff;
  logic [spm_pkg::CLKC_W-1:0] clkc_ff;
  logic [spm_pkg::BAUD_W-1:0] baud_ff;
  logic [7:0] data_ff;
  logic done_ff;
  logic start_ff;
  logic ring_s1_ff, ring_s2_ff, pll_s1_ff, pll_s2_ff;
  logic sdi_s1_ff, sdi_s2_ff, sio_s1_ff, sio_s2_ff;
  logic src_prev_ff;
  logic [7:0] div_cnt_ff;
  logic tick_ff;
  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [11:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wstrb0_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic fs_change, aw_take, w_take, wr_fire, wr_ok, ar_take;
  logic src_sel, div_run, sin_sel;
  logic [7:0] div_lim, rd_byte;
  logic sh_sclk, sh_sdo, sh_busy, sh_done;
  logic [7:0] sh_rx;

  assign fs_change = port_power_down_in != fs_ff;
  assign aw_take = s_axi_awvalid && awready_ff;
  assign w_take = s_axi_wvalid && wready_ff;
  assign wr_fire = aw_full_ff && w_full_ff;
  assign wr_ok = wr_fire && wstrb0_ff && !fs_change;
  assign ar_take = s_axi_arvalid && arready_ff;

  ////////////////////////////////////////////////////////////////////////
  // function select follows its input; reset value keeps pins as gpio
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fs_ff <= 1'b0;
    end else begin
      fs_ff <= port_power_down_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for clock sources and serial inputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ring_s1_ff <= 1'b0;
      ring_s2_ff <= 1'b0;
      pll_s1_ff <= 1'b0;
      pll_s2_ff <= 1'b0;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
      sio_s1_ff <= 1'b0;
      sio_s2_ff <= 1'b0;
    end else begin
      ring_s1_ff <= ring_oscillator_clock;
      ring_s2_ff <= ring_s1_ff;
      pll_s1_ff <= pll_clock_input;
      pll_s2_ff <= pll_s1_ff;
      sdi_s1_ff <= data_in_pin_i;
      sdi_s2_ff <= sdi_s1_ff;
      sio_s1_ff <= data_out_pin_i;
      sio_s2_ff <= sio_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud divider: one tick per 2**baud rising source edges, one tick per serial clock edge
  // sources are sampled, so each must toggle slower than a quarter of clock
  assign src_sel = clkc_ff[spm_pkg::CLKC_SRC] ? pll_s2_ff : ring_s2_ff;
  assign div_run = fs_ff && clkc_ff[spm_pkg::CLKC_GATE];
  assign div_lim = 8'(8'h01 << baud_ff) - 8'h01;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_prev_ff <= 1'b0;
      div_cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_sel;
      tick_ff <= 1'b0;
      if (!div_run || start_ff) begin
        div_cnt_ff <= 8'h00;
      end else if (src_sel && !src_prev_ff) begin
        if (div_cnt_ff >= div_lim) begin
          div_cnt_ff <= 8'h00;
          tick_ff <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus write side: address and data taken in either order
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= spm_pkg::RESP_OKAY;
      awaddr_ff <= 12'h000;
      wbyte_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_mapped(awaddr_ff) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      awready_ff <= !(aw_full_ff || aw_take || bvalid_ff);
      wready_ff <= !(w_full_ff || w_take || bvalid_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus read side; reads have no side effects
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(s_axi_araddr, spm_pkg::IDX_CTRL)) begin
      rd_byte[spm_pkg::CTRL_MODE] = mode_ff;
      rd_byte[spm_pkg::CTRL_SHARED_OE] = shared_oe_ff;
    end else if (reg_hit(s_axi_araddr, spm_pkg::IDX_STAT)) begin
      // idle held back during the done pulse so it never reads ahead of done
      rd_byte[spm_pkg::STAT_IDLE] = !sh_busy && !start_ff && !sh_done;
      rd_byte[spm_pkg::STAT_DONE] = done_ff;
    end else if (reg_hit(s_axi_araddr, spm_pkg::IDX_DATA)) begin
      rd_byte = data_ff;
    end else if (reg_hit(s_axi_araddr, spm_pkg::IDX_CLKC)) begin
      rd_byte = {3'h0, clkc_ff};
    end else if (reg_hit(s_axi_araddr, spm_pkg::IDX_BAUD)) begin
      rd_byte = {5'h00, baud_ff};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= spm_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= reg_mapped(s_axi_araddr) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
      arready_ff <= !(ar_take || rvalid_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port registers; a select change wipes them all
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff <= spm_pkg::RST_MODE;
      shared_oe_ff <= spm_pkg::RST_SHARED_OE;
      clkc_ff <= spm_pkg::RST_CLKC;
      baud_ff <= spm_pkg::RST_BAUD;
    end else if (fs_change) begin
      mode_ff <= spm_pkg::RST_MODE;
      shared_oe_ff <= spm_pkg::RST_SHARED_OE;
      clkc_ff <= spm_pkg::RST_CLKC;
      baud_ff <= spm_pkg::RST_BAUD;
    end else if (wr_ok) begin
      if (reg_hit(awaddr_ff, spm_pkg::IDX_CTRL)) begin
        mode_ff <= wbyte_ff[spm_pkg::CTRL_MODE];
        shared_oe_ff <= wbyte_ff[spm_pkg::CTRL_SHARED_OE];
      end
      if (reg_hit(awaddr_ff, spm_pkg::IDX_CLKC)) begin
        clkc_ff <= wbyte_ff[spm_pkg::CLKC_W-1:0];
      end
      if (reg_hit(awaddr_ff, spm_pkg::IDX_BAUD)) begin
        baud_ff <= wbyte_ff[spm_pkg::BAUD_W-1:0];
      end
    end
  end

  // transfer starts only from an idle, selected port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_ff <= spm_pkg::RST_DATA;
      start_ff <= 1'b0;
    end else if (fs_change) begin
      data_ff <= spm_pkg::RST_DATA;
      start_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (sh_done) begin
        // a bidirectional send keeps the sent character
        data_ff <= (mode_ff && shared_oe_ff) ? data_ff : sh_rx;
      end else if (wr_ok && reg_hit(awaddr_ff, spm_pkg::IDX_DATA) && fs_ff && !sh_busy && !start_ff) begin
        data_ff <= wbyte_ff;
        start_ff <= 1'b1;
      end
    end
  end

  // completion flag: write one to clear, a new completion wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      port_interrupt <= 1'b0;
    end else begin
      if (fs_change) begin
        done_ff <= 1'b0;
      end else if (sh_done) begin
        done_ff <= 1'b1;
      end else if (wr_ok && reg_hit(awaddr_ff, spm_pkg::IDX_STAT) && wbyte_ff[spm_pkg::STAT_DONE]) begin
        done_ff <= 1'b0;
      end
      port_interrupt <= done_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign sin_sel = mode_ff ? sio_s2_ff : sdi_s2_ff;

  spm_shifter i_spm_shifter (
    .clock(clock),
    .rst(rst),
    .clear(fs_change),
    .tick(tick_ff),
    .start(start_ff),
    .tx_byte(data_ff),
    .cpol(clkc_ff[spm_pkg::CLKC_CPOL]),
    .tedge(clkc_ff[spm_pkg::CLKC_TEDGE]),
    .redge(clkc_ff[spm_pkg::CLKC_REDGE]),
    .sin(sin_sel),
    .sclk(sh_sclk),
    .sdo(sh_sdo),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin sharing between the port and general I/O
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      data_out_pin_o <= 1'b0;
      data_out_pin_oe <= 1'b0;
      data_in_pin_o <= 1'b0;
      data_in_pin_oe <= 1'b0;
    end else if (fs_ff) begin
      serial_clock_pin_o <= sh_sclk;
      serial_clock_pin_oe <= 1'b1;
      data_out_pin_o <= sh_sdo;
      data_out_pin_oe <= mode_ff ? shared_oe_ff : 1'b1;
      data_in_pin_o <= mode_ff ? shared_gpio_c_level : 1'b0;
      data_in_pin_oe <= mode_ff ? shared_gpio_c_dir : 1'b0;
    end else begin
      serial_clock_pin_o <= shared_gpio_a_level;
      serial_clock_pin_oe <= shared_gpio_a_dir;
      data_out_pin_o <= shared_gpio_b_level;
      data_out_pin_oe <= shared_gpio_b_dir;
      data_in_pin_o <= shared_gpio_c_level;
      data_in_pin_oe <= shared_gpio_c_dir;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_data_write_dropped;
    @(posedge clock) disable iff (rst)
    (wr_ok && reg_hit(awaddr_ff, spm_pkg::IDX_DATA) && !fs_ff) |=> !start_ff;
  endproperty
  a_data_write_dropped: assert property (p_data_write_dropped) else $error("data write started a transfer while deselected");

  property p_no_tick_deselected;
    @(posedge clock) disable iff (rst)
    !fs_ff |=> !tick_ff;
  endproperty
  a_no_tick_deselected: assert property (p_no_tick_deselected) else $error("baud tick while deselected");

  property p_select_change_reset;
    @(posedge clock) disable iff (rst)
    fs_change |=> (clkc_ff == spm_pkg::RST_CLKC && mode_ff == spm_pkg::RST_MODE && !done_ff && !sh_busy);
  endproperty
  a_select_change_reset: assert property (p_select_change_reset) else $error("registers not reset on select change");

  property p_done_flag;
    @(posedge clock) disable iff (rst)
    (sh_done && !fs_change) |=> done_ff ##1 port_interrupt;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

  property p_irq_follows;
    @(posedge clock) disable iff (rst)
    $rose(done_ff) |=> port_interrupt;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing after completion");

  property p_busy_holds;
    @(posedge clock) disable iff (rst)
    (start_ff && !fs_change) |=> sh_busy [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");

  property p_rx_kept;
    @(posedge clock) disable iff (rst)
    (sh_done && !fs_change && !(mode_ff && shared_oe_ff)) |=> data_ff == $past(sh_rx);
  endproperty
  a_rx_kept: assert property (p_rx_kept) else $error("received character not stored");

  property p_full_duplex_pins;
    @(posedge clock) disable iff (rst)
    (fs_ff && !mode_ff) |=> (serial_clock_pin_oe && data_out_pin_oe && !data_in_pin_oe);
  endproperty
  a_full_duplex_pins: assert property (p_full_duplex_pins) else $error("full duplex pin roles wrong");

  property p_bidir_in_pin;
    @(posedge clock) disable iff (rst)
    (fs_ff && mode_ff) |=> data_in_pin_oe == $past(shared_gpio_c_dir);
  endproperty
  a_bidir_in_pin: assert property (p_bidir_in_pin) else $error("data-in pin not returned to gpio");

  property p_shared_line_dir;
    @(posedge clock) disable iff (rst)
    (fs_ff && mode_ff) |=> data_out_pin_oe == $past(shared_oe_ff);
  endproperty
  a_shared_line_dir: assert property (p_shared_line_dir) else $error("shared line direction wrong");

  property p_idle_clock_level;
    @(posedge clock) disable iff (rst)
    (fs_ff && !sh_busy && !$past(sh_busy) && $stable(clkc_ff)) |=>
      serial_clock_pin_o == $past(clkc_ff[spm_pkg::CLKC_CPOL]);
  endproperty
  a_idle_clock_level: assert property (p_idle_clock_level) else $error("idle clock level ignores polarity");

endmodule // spm_port

// >>> sim/spm_slave_model.sv
// behavioural serial slave, msb first; late picks trailing-edge sampling
// assumes the clock idles low and tx is loaded before each character
`timescale 1ns/1ps
module spm_slave_model (
  input wire logic sclk,
  input wire logic sdi,
  input wire logic load,
  input wire logic late,
  input wire logic [7:0] tx,
  output logic sdo,
  output logic [7:0] rx
);
  logic [7:0] sh_ff;
  logic out_ff;
  // early: sample rising, shift falling; late: drive rising, sample falling
  always @(posedge sclk or negedge sclk) begin
    if (sclk != late) begin
      rx <= {rx[6:0], sdi};
    end
  end
  always @(posedge sclk) begin
    out_ff <= sh_ff[7];
  end
  always @(posedge sclk or negedge sclk or posedge load) begin
    if (load) begin
      sh_ff <= tx;
    end else if (sclk == late) begin
      // inverted fill keeps a spent line moving, never a stale level
      sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
    end
  end
  assign sdo = late ? out_ff : sh_ff[7];
endmodule // spm_slave_model

// >>> sim/spm_port_tb.sv
// self-checking bench for the serial port master
// assumes the slave model in sim/ and a free-running ring and pll source
`timescale 1ns/1ps
module spm_port_tb;
  localparam logic [11:0] A_CTRL = {2'h0, spm_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, spm_pkg::IDX_STAT, 2'h0};
  localparam logic [11:0] A_DATA = {2'h0, spm_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_CLKC = {2'h0, spm_pkg::IDX_CLKC, 2'h0};
  localparam logic [11:0] A_BAUD = {2'h0, spm_pkg::IDX_BAUD, 2'h0};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, sel = 1'b0, ring = 1'b0, pll = 1'b0, load = 1'b0;
  logic late = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdat, rdata;
  logic [2:0] gl = 3'h5, gd = 3'h7;
  logic [7:0] stx = 8'h00, srx;
  logic [1:0] rsp, bresp, rresp;
  logic awr, wrr, bv, arr, rv, sck_o, sck_oe, do_o, do_oe, di_o, di_oe, irq, miso;
  int fail_count = 0, comparisons = 0, cyc = 0;
  wire sck_i = sck_oe ? sck_o : 1'b0;
  wire do_i = do_oe ? do_o : miso;
  wire di_i = di_oe ? di_o : miso;
  always #20 clock = ~clock;
  always #160 ring = ~ring;
  always #200 pll = ~pll;
  spm_port i_spm_port (.clock(clock), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .port_power_down_in(sel),
    .ring_oscillator_clock(ring), .pll_clock_input(pll), .shared_gpio_a_level(gl[0]), .shared_gpio_a_dir(gd[0]),
    .shared_gpio_b_level(gl[1]), .shared_gpio_b_dir(gd[1]), .shared_gpio_c_level(gl[2]),
    .shared_gpio_c_dir(gd[2]), .serial_clock_pin_i(sck_i), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe), .data_out_pin_i(do_i), .data_out_pin_o(do_o), .data_out_pin_oe(do_oe),
    .data_in_pin_i(di_i), .data_in_pin_o(di_o), .data_in_pin_oe(di_oe), .port_interrupt(irq));
  spm_slave_model i_spm_slave_model (.sclk(sck_i), .sdi(do_o), .load(load), .late(late), .tx(stx),
    .sdo(miso), .rx(srx));
  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clock);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = bresp;
    bry <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clock);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    rdat = rdata;
    rsp = rresp;
    rry <= 1'b0;
    @(posedge clock);
  endtask
  task xfer(input logic [7:0] d, input logic [7:0] s, input logic [7:0] e);
    int n;
    stx <= s;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    wr(A_DATA, d);
    rd(A_STAT);
    chk("busy", 32'h0, rdat & 32'h1);
    n = 0;
    do begin
      rd(A_STAT);
      n++;
    end while (rdat[0] !== 1'b1 && n < 100);
    chk("status", 32'h3, rdat);
    chk("interrupt", 32'h1, {31'h0, irq});
    rd(A_DATA);
    chk("data", {24'h0, e}, rdat);
    chk("slave got", {24'h0, d}, {24'h0, srx});
    wr(A_STAT, 8'h02);
    rd(A_STAT);
    chk("done cleared", 32'h1, rdat);
    chk("interrupt cleared", 32'h0, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset();
    logic [11:0] regs [4];
    regs = '{A_CTRL, A_DATA, A_CLKC, A_BAUD};
    foreach (regs[i]) begin
      rd(regs[i]);
      chk("reset value", 32'h0, rdat);
    end
    rd(A_STAT);
    chk("idle", 32'h1, rdat);
    rd(12'h000);
    chk("unmapped", {30'h0, spm_pkg::RESP_SLVERR}, {30'h0, rsp});
    chk("gpio pin", 32'h3, {30'h0, sck_oe, sck_o});
    $display("test reset done");
  endtask
  task t_gated();
    wr(A_CLKC, 8'h08);
    wr(A_DATA, 8'h5a);
    rd(A_DATA);
    chk("gated data", 32'h0, rdat);
    rd(A_STAT);
    chk("gated idle", 32'h1, rdat);
    $display("test gated done");
  endtask
  task t_pins();
    sel <= 1'b1;
    repeat (3) @(posedge clock);
    chk("port pins", 32'ha, {28'h0, sck_oe, sck_o, do_oe, di_oe});
    wr(A_CLKC, 8'h0a);
    repeat (3) @(posedge clock);
    chk("idle polarity", 32'h1, {31'h0, sck_o});
    wr(A_BAUD, 8'h07);
    rd(A_BAUD);
    chk("baud", 32'h7, rdat);
    wr(A_BAUD, 8'h00);
    wr(A_CLKC, 8'h08);
    $display("test pins done");
  endtask
  task t_duplex();
    xfer(8'ha5, 8'h3c, 8'h3c);
    xfer(8'h01, 8'h80, 8'h80);
    // both edge choices flipped: drive on leading, sample on trailing
    wr(A_CLKC, 8'h19);
    late <= 1'b1;
    xfer(8'h3a, 8'hc5, 8'hc5);
    late <= 1'b0;
    $display("test duplex done");
  endtask
  task t_bidir();
    wr(A_CLKC, 8'h0c);
    wr(A_CTRL, 8'h06);
    repeat (3) @(posedge clock);
    chk("shared pins", 32'h7, {29'h0, do_oe, di_oe, di_o});
    xfer(8'h96, 8'h00, 8'h96);
    wr(A_CTRL, 8'h02);
    repeat (3) @(posedge clock);
    chk("listen", 32'h0, {31'h0, do_oe});
    // data-in pin is held high by gpio, so reading it would give ff
    xfer(8'h00, 8'hc3, 8'hc3);
    $display("test bidir done");
  endtask
  task t_select();
    sel <= 1'b0;
    repeat (3) @(posedge clock);
    rd(A_CTRL);
    chk("ctrl default", 32'h0, rdat);
    rd(A_CLKC);
    chk("clkc default", 32'h0, rdat);
    chk("gpio again", 32'h3, {30'h0, sck_oe, sck_o});
    $display("test select done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_gated();
    t_pins();
    t_duplex();
    t_bidir();
    t_select();
    tally_and_finish();
  end
endmodule // spm_port_tb
